// file: shared/thermo_regs_defs.svh
`ifndef THERMO_REGS_DEFS_SVH
`define THERMO_REGS_DEFS_SVH

// Register offsets
`define OFF_HIGH_UPPER   8'h10
`define OFF_HIGH_LOWER   8'h11
`define OFF_LOW_UPPER    8'h12
`define OFF_LOW_LOWER    8'h13
`define OFF_MEAS_SETUP   8'h14
`define OFF_PIN_FUNC     8'h20
`define OFF_PIN_LEVEL    8'h21
`define OFF_IRQ_ENABLE   8'h22

// Reset values
`define RST_HIGH_UPPER   8'h7F
`define RST_HIGH_LOWER   8'hFF
`define RST_LOW_UPPER    8'h80
`define RST_LOW_LOWER    8'h00
`define RST_PIN_FUNC     6'h2A
`define RST_PIN_LEVEL    3'h0
`define RST_IRQ_ENABLE   1'h0

// Field positions
`define BIT_START        0
`define RESERVED_ONES    2'h3
`define BIT_HIGH_IRQ_EN  0

`endif

// file: shared/thermo_regs_pkg.sv
package thermo_regs_pkg;
  typedef enum logic [1:0] {
    PIN_INPUT_HIZ   = 2'h0,
    PIN_OUTPUT_OD   = 2'h1,
    PIN_INPUT_PULL  = 2'h2,
    PIN_SPECIAL     = 2'h3
  } pin_mode_type;

  typedef enum logic [1:0] {
    MEAS_IDLE = 2'h0,
    MEAS_BUSY = 2'h1,
    MEAS_DONE = 2'h3
  } meas_state_type;
endpackage

// file: core/pin_cell.sv
`timescale 1ns/1ps
module pin_cell
  import thermo_regs_pkg::*;
(
  // Configuration
  input  wire thermo_regs_pkg::pin_mode_type i_mode,
  input  wire logic                          i_level,
  input  wire logic                          i_special_drive_low,
  // Pad
  input  wire logic                          i_pad,
  output logic                               o_pad,
  output logic                               o_pad_oe,
  output logic                               o_pulldown_en,
  output logic                               o_level
);
  // Open drain: only ever drive low
  always_comb begin
    o_pad         = 1'b0;
    o_pad_oe      = 1'b0;
    o_pulldown_en = 1'b0;
    case (i_mode)
      PIN_INPUT_HIZ:  o_pad_oe = 1'b0;                 // RL8
      PIN_OUTPUT_OD:  o_pad_oe = ~i_level;             // RL9
      PIN_INPUT_PULL: o_pulldown_en = 1'b1;            // RL10
      PIN_SPECIAL:    o_pad_oe = i_special_drive_low;
      default:        o_pad_oe = 1'b0;
    endcase
  end
  // Level bit always reflects the pad, whatever the mode
  assign o_level = i_pad; // RL15
endmodule

// file: core/meas_ctrl.sv
`timescale 1ns/1ps
module meas_ctrl
  import thermo_regs_pkg::*;
(
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  // Requests
  input  wire logic i_start,
  // Engine
  input  wire logic i_done,
  output logic      o_start_pulse,
  output logic      o_busy
);
  meas_state_type state_reg;
  meas_state_type state_next;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MEAS_IDLE: if (i_start) state_next = MEAS_BUSY;
      MEAS_BUSY: if (i_done) state_next = MEAS_DONE; // RL7
      MEAS_DONE: state_next = MEAS_IDLE;
      default:   state_next = MEAS_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_reg <= MEAS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // A start during a running measurement is absorbed, not queued
  assign o_start_pulse = (state_reg == MEAS_IDLE) && i_start;
  assign o_busy        = (state_reg == MEAS_BUSY);
endmodule

// file: core/thermo_regs.sv
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "thermo_regs_defs.svh"
// Operation
// (RL1) High limit lower byte is its own RW register at 0x11.
// (RL2) High limit resets to 0x7FFF, alarm effectively disabled.
// (RL3) Low limit upper byte at 0x12, lower at 0x13, both RW.
// (RL4) Low limit resets to 0x8000, alarm effectively disabled.
// (RL5) Host must write ones into setup bits 7:6; device keeps them read-only.
// (RL6) Writing one to setup bit 0 starts a measurement.
// (RL7) Start bit self-clears when the measurement completes.
// (RL8) Pin mode 00 is high-impedance input, level read back.
// (RL9) Pin mode 01 is open-drain output following the level bit.
// (RL10) Pin mode 10 is input with weak pulldown.
// (RL11) Pin one mode 11 is active-low conversion trigger input.
// (RL12) Pin zero mode 11 is active-low open-drain interrupt output.
// (RL13) Host should not program pin two mode 11.
// (RL14) High limit upper byte at 0x10 joins lower byte.
// (RL15) Level bit read returns the pin's present level in any mode.
// (RL16) High alarm reaches pin zero only when enabled and pin zero is interrupt.
// (RL17) Start bit reads one while busy; reserved bits read ones.
module thermo_regs
  import thermo_regs_pkg::*;
(
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  // Register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  // Measurement engine
  input  wire logic        i_meas_done,
  input  wire logic        i_high_alarm,
  output logic             o_meas_start,
  output logic             o_meas_busy,
  output logic      [15:0] o_high_limit,
  output logic      [15:0] o_low_limit,
  // General pins
  input  wire logic [2:0]  i_pin,
  output logic      [2:0]  o_pin,
  output logic      [2:0]  o_pin_oe,
  output logic      [2:0]  o_pin_pulldown_en
);
  logic [7:0] high_limit_upper_byte_reg;
  logic [7:0] high_limit_lower_byte_reg;
  logic [7:0] low_limit_upper_byte_reg;
  logic [7:0] low_limit_lower_byte_reg;
  logic [5:0] pin_func_reg;
  logic [2:0] pin_level_reg;
  logic       high_alarm_irq_enable_reg;
  logic [7:0] rdata_reg;
  logic       trig_prev_reg;
  logic [2:0] pin_level_in;
  logic       host_start;
  logic       trig_start;
  logic       irq_drive_low;
  pin_mode_type pin_zero_function;
  pin_mode_type pin_one_function;
  pin_mode_type pin_two_function;

  assign pin_zero_function = pin_mode_type'(pin_func_reg[1:0]);
  assign pin_one_function  = pin_mode_type'(pin_func_reg[3:2]);
  assign pin_two_function  = pin_mode_type'(pin_func_reg[5:4]);

  // Threshold bytes
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      high_limit_upper_byte_reg <= `RST_HIGH_UPPER;  // RL2
      high_limit_lower_byte_reg <= `RST_HIGH_LOWER;  // RL2
      low_limit_upper_byte_reg  <= `RST_LOW_UPPER;   // RL4
      low_limit_lower_byte_reg  <= `RST_LOW_LOWER;   // RL4
    end else if (i_wr) begin
      case (i_addr)
        `OFF_HIGH_UPPER: high_limit_upper_byte_reg <= i_wdata; // RL14
        `OFF_HIGH_LOWER: high_limit_lower_byte_reg <= i_wdata; // RL1
        `OFF_LOW_UPPER:  low_limit_upper_byte_reg  <= i_wdata; // RL3
        `OFF_LOW_LOWER:  low_limit_lower_byte_reg  <= i_wdata; // RL3
        default: ;
      endcase
    end
  end

  assign o_high_limit = {high_limit_upper_byte_reg, high_limit_lower_byte_reg}; // RL14
  assign o_low_limit  = {low_limit_upper_byte_reg, low_limit_lower_byte_reg};   // RL3

  // Pin configuration
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pin_func_reg              <= `RST_PIN_FUNC;
      pin_level_reg             <= `RST_PIN_LEVEL;
      high_alarm_irq_enable_reg <= `RST_IRQ_ENABLE;
    end else if (i_wr) begin
      case (i_addr)
        `OFF_PIN_FUNC:   pin_func_reg  <= i_wdata[5:0];
        `OFF_PIN_LEVEL:  pin_level_reg <= i_wdata[2:0];
        `OFF_IRQ_ENABLE: high_alarm_irq_enable_reg <= i_wdata[`BIT_HIGH_IRQ_EN];
        default: ;
      endcase
    end
  end

  // Measurement start: host bit or falling edge on trigger pin
  assign host_start = i_wr && (i_addr == `OFF_MEAS_SETUP) && i_wdata[`BIT_START]; // RL6

  // Previous level held high outside trigger mode, so entering trigger mode with the pin low counts as a start
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      trig_prev_reg <= 1'b1;
    end else begin
      trig_prev_reg <= i_pin[1] | (pin_one_function != PIN_SPECIAL);
    end
  end

  assign trig_start = (pin_one_function == PIN_SPECIAL) && trig_prev_reg && !i_pin[1]; // RL11

  meas_ctrl u_meas_ctrl (
    .i_ref_clk     (i_ref_clk),
    .i_rst         (i_rst),
    .i_start       (host_start | trig_start),
    .i_done        (i_meas_done),
    .o_start_pulse (o_meas_start),
    .o_busy        (o_meas_busy)
  );

  // Interrupt on pin zero, active low
  assign irq_drive_low = high_alarm_irq_enable_reg && i_high_alarm
                         && (pin_zero_function == PIN_SPECIAL); // RL16 RL12

  pin_cell u_pin_zero (
    .i_mode              (pin_zero_function),
    .i_level             (pin_level_reg[0]),
    .i_special_drive_low (irq_drive_low),
    .i_pad               (i_pin[0]),
    .o_pad               (o_pin[0]),
    .o_pad_oe            (o_pin_oe[0]),
    .o_pulldown_en       (o_pin_pulldown_en[0]),
    .o_level             (pin_level_in[0])
  );

  // Trigger input is never driven by the device
  pin_cell u_pin_one (
    .i_mode              (pin_one_function),
    .i_level             (pin_level_reg[1]),
    .i_special_drive_low (1'b0),
    .i_pad               (i_pin[1]),
    .o_pad               (o_pin[1]),
    .o_pad_oe            (o_pin_oe[1]),
    .o_pulldown_en       (o_pin_pulldown_en[1]),
    .o_level             (pin_level_in[1])
  );

  // Mode 11 on pin two has no function; pin stays undriven
  pin_cell u_pin_two (
    .i_mode              (pin_two_function),
    .i_level             (pin_level_reg[2]),
    .i_special_drive_low (1'b0),
    .i_pad               (i_pin[2]),
    .o_pad               (o_pin[2]),
    .o_pad_oe            (o_pin_oe[2]),
    .o_pulldown_en       (o_pin_pulldown_en[2]),
    .o_level             (pin_level_in[2])
  );

  // Read data, one cycle after the strobe
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rdata_reg <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `OFF_HIGH_UPPER: rdata_reg <= high_limit_upper_byte_reg;
        `OFF_HIGH_LOWER: rdata_reg <= high_limit_lower_byte_reg;
        `OFF_LOW_UPPER:  rdata_reg <= low_limit_upper_byte_reg;
        `OFF_LOW_LOWER:  rdata_reg <= low_limit_lower_byte_reg;
        `OFF_MEAS_SETUP: rdata_reg <= {`RESERVED_ONES, 5'h00, o_meas_busy}; // RL17 RL5
        `OFF_PIN_FUNC:   rdata_reg <= {2'h0, pin_func_reg};
        `OFF_PIN_LEVEL:  rdata_reg <= {5'h00, pin_level_in}; // RL15
        `OFF_IRQ_ENABLE: rdata_reg <= {7'h00, high_alarm_irq_enable_reg};
        default:         rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign o_rdata = rdata_reg;
endmodule

// file: verif/thermo_regs_props.sv
`timescale 1ns/1ps
module thermo_regs_props (
  // Clock, strobes and engine
  input wire logic        i_ref_clk, i_rst, i_wr, i_rd, i_meas_done, o_meas_start, o_meas_busy,
  // Buses and pins
  input wire logic [7:0]  i_addr, i_wdata, o_rdata,
  input wire logic [15:0] o_high_limit, o_low_limit,
  input wire logic [2:0]  i_pin, o_pin, o_pin_pulldown_en
);
  logic [7:0] wd_reg;
  always_ff @(posedge i_ref_clk) wd_reg <= i_wdata;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  sequence s_finish;
    o_meas_busy && i_meas_done;
  endsequence
  // Starts in the finishing cycle are dropped, so busy stays low two edges
  sequence s_rest;
    !o_meas_busy && !o_meas_start ##1 !o_meas_busy;
  endsequence
  a_start_busy: assert property (o_meas_start |=> o_meas_busy)
    else $error("start lost");
  a_done_clear: assert property (s_finish |=> s_rest)
    else $error("busy stuck");
  a_setup_read: assert property (i_rd && i_addr == 8'h14 |=> o_rdata == {2'h3, 5'h00, $past(o_meas_busy)})
    else $error("setup read");
  a_high_lower: assert property (i_wr && i_addr == 8'h11 |=> o_high_limit[7:0] == $past(i_wdata))
    else $error("high lower");
  a_low_upper: assert property (i_wr && i_addr == 8'h12 |=> o_low_limit[15:8] == $past(i_wdata))
    else $error("low upper");
  a_pull_mode: assert property (i_wr && i_addr == 8'h20 |=>
    o_pin_pulldown_en == {wd_reg[5:4] == 2'h2, wd_reg[3:2] == 2'h2, wd_reg[1:0] == 2'h2})
    else $error("pulldown");
  a_level_read: assert property (i_rd && i_addr == 8'h21 |=> o_rdata[2:0] == $past(i_pin))
    else $error("level read");
  a_od_low: assert property (o_pin == 3'h0)
    else $error("pad driven high");
endmodule

// file: verif/pad_world.sv
`timescale 1ns/1ps
module pad_world (
  // Clock, reset and engine
  input  wire logic       i_ref_clk, i_rst, i_slow, i_start,
  output logic            o_done,
  // Pads
  input  wire logic [2:0] i_oe, i_pull, i_ext_en, i_ext_val,
  output logic      [2:0] o_pad
);
  logic [4:0] cnt_reg;
  logic [2:0] float_reg;
  // Engine answers after 3 or 20 cycles; both cases let reads see busy
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || i_start) begin
      cnt_reg <= i_rst ? 5'h00 : (i_slow ? 5'h14 : 5'h03);
    end else if (cnt_reg != 5'h00) begin
      cnt_reg <= cnt_reg - 5'h01;
    end
    o_done <= !i_rst && cnt_reg == 5'h01;
  end
  // A floating pad toggles so no read of it passes by chance
  always_ff @(posedge i_ref_clk) float_reg <= i_rst ? 3'h5 : ~float_reg;
  always_comb begin
    for (int n = 0; n < 3; n++) begin
      o_pad[n] = i_oe[n] ? 1'b0 : i_ext_en[n] ? i_ext_val[n] : i_pull[n] ? 1'b0 : float_reg[n];
    end
  end
endmodule

// file: verif/thermo_regs_bench.sv
`timescale 1ns/1ps
module thermo_regs_bench;
  logic i_ref_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_high_alarm = 0, slow = 0, rd_d = 0;
  logic [7:0]  i_addr = 0, i_wdata = 0, o_rdata;
  logic [2:0]  ext_en = 0, ext_val = 0, i_pin, o_pin, o_pin_oe, o_pin_pulldown_en, lv, v;
  logic [15:0] o_high_limit, o_low_limit, hi, lo, nt, q[$];
  logic        o_meas_start, o_meas_busy, i_meas_done;
  int          bad_count = 0, tests_run = 0, seed = 6566;
  always #2 i_ref_clk = ~i_ref_clk;
  thermo_regs dut_u (.i_ref_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_meas_done, .i_high_alarm,
    .o_meas_start, .o_meas_busy, .o_high_limit, .o_low_limit, .i_pin, .o_pin, .o_pin_oe, .o_pin_pulldown_en);
  pad_world pw_u (.i_ref_clk, .i_rst, .i_slow(slow), .i_start(o_meas_start), .o_done(i_meas_done),
    .i_oe(o_pin_oe), .i_pull(o_pin_pulldown_en), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pad(i_pin));
  task automatic chk(input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, dt);
    @(posedge i_ref_clk);
    {i_wr, i_rd, i_addr, i_wdata} <= {2'h2, a, dt};
  endtask
  // Note holds the read mask above the expected byte
  task automatic rd(input logic [7:0] a, input logic [15:0] note);
    @(posedge i_ref_clk);
    {i_wr, i_rd, i_addr} <= {2'h1, a};
    q.push_back(note);
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge i_ref_clk) {i_wr, i_rd} <= 2'h0;
  endtask
  task automatic wait_busy(input logic b);
    int n;
    n = 0;
    while (o_meas_busy !== b && n < 100) @(posedge i_ref_clk) n++;
    tests_run++;
    if (n == 100) begin
      bad_count++;
      $display("ERROR %0t: busy wait ran out", $time);
      test_done();
    end
  endtask
  always @(posedge i_ref_clk) begin
    rd_d <= i_rd;
    if (rd_d) begin
      nt = q.pop_front();
      chk(o_rdata & nt[15:8], nt[7:0]);
    end
  end
  initial begin
    repeat (4) @(posedge i_ref_clk);
    i_rst <= 0;
    rd(8'h10, 16'hFF7F);
    rd(8'h11, 16'hFFFF);
    rd(8'h12, 16'hFF80);
    rd(8'h13, 16'hFF00);
    rd(8'h20, 16'hFF2A);
    rd(8'h30, 16'hFF00);
    idle(2);
    chk(o_high_limit, 16'h7FFF);
    chk(o_low_limit, 16'h8000);
    hi = 16'($random(seed));
    lo = 16'($random(seed));
    wr(8'h10, hi[15:8]);
    wr(8'h11, hi[7:0]);
    wr(8'h12, lo[15:8]);
    wr(8'h13, lo[7:0]);
    rd(8'h11, {8'hFF, hi[7:0]});
    rd(8'h13, {8'hFF, lo[7:0]});
    idle(2);
    chk(o_high_limit, hi);
    chk(o_low_limit, lo);
    for (int s = 0; s < 2; s++) begin
      slow <= s[0];
      wr(8'h14, 8'hC1);
      rd(8'h14, 16'hFFC1);
      idle(1);
      wait_busy(1'b0);
      rd(8'h14, 16'hFFC0);
      idle(1);
    end
    for (int m = 0; m < 3; m++) begin
      lv = 3'($random(seed));
      v = 3'($random(seed));
      ext_en <= 3'h7;
      ext_val <= v;
      wr(8'h21, {5'h00, lv});
      wr(8'h20, {2'h0, m[1:0], m[1:0], m[1:0]});
      rd(8'h21, {8'hFF, 5'h00, (m == 1) ? (v & lv) : v});
      idle(2);
      chk(o_pin_oe, (m == 1) ? lv ^ 3'h7 : 3'h0);
      chk(o_pin_pulldown_en, (m == 2) ? 3'h7 : 3'h0);
    end
    ext_val <= 3'h7;
    wr(8'h20, 8'h2E);
    idle(2);
    ext_val <= 3'h5;
    wait_busy(1'b1);
    wait_busy(1'b0);
    wr(8'h20, 8'h23);
    wr(8'h22, 8'h01);
    i_high_alarm <= 1;
    idle(2);
    chk(o_pin_oe[0], 1'b1);
    // Alarm and enable still high, but pin zero is no longer the interrupt
    wr(8'h20, 8'h20);
    idle(2);
    chk(o_pin_oe[0], 1'b0);
    wr(8'h20, 8'h23);
    i_high_alarm <= 0;
    idle(2);
    chk(o_pin_oe[0], 1'b0);
    i_high_alarm <= 1;
    wr(8'h22, 8'h00);
    idle(2);
    chk(o_pin_oe[0], 1'b0);
    // Second reset after every register was changed
    i_rst <= 1;
    idle(2);
    i_rst <= 0;
    rd(8'h10, 16'hFF7F);
    rd(8'h13, 16'hFF00);
    rd(8'h20, 16'hFF2A);
    rd(8'h14, 16'hFFC0);
    idle(2);
    chk(o_high_limit, 16'h7FFF);
    chk(o_low_limit, 16'h8000);
    chk(o_pin_oe, 3'h0);
    chk(o_pin_pulldown_en, 3'h7);
    test_done();
  end
endmodule
bind thermo_regs thermo_regs_props props_u (.i_ref_clk, .i_rst, .i_wr, .i_rd, .i_meas_done, .o_meas_start,
  .o_meas_busy, .i_addr, .i_wdata, .o_rdata, .o_high_limit, .o_low_limit, .i_pin, .o_pin, .o_pin_pulldown_en);
